/* mcu_branch_defs.vh */
/*
 * Constants of the branch, increment-skip, trap, OR and special page store
 * execution slice: operation codes, field widths, addresses and cycle counts.
 * Assumes it is included by its bare name from the design files of the slice.
 */
`ifndef MCU_BRANCH_DEFS_VH
`define MCU_BRANCH_DEFS_VH

// ============================================================================
// Operation codes on the request port
// ============================================================================
`define OP_WIDTH 3
`define OP_COMPUTED_JUMP 3'h0
`define OP_INCREMENT_SKIP_ZERO 3'h1
`define OP_SOFTWARE_TRAP 3'h2
`define OP_OR_IMMEDIATE 3'h3
`define OP_OR_REGISTER 3'h4
`define OP_SPECIAL_PAGE_STORE 3'h5

// ============================================================================
// Widths and addresses
// ============================================================================
`define PC_WIDTH 11
`define DATA_WIDTH 8
`define RF_ADDR_WIDTH 7
`define RF_DEPTH 128
`define SP_ADDR_WIDTH 4
`define SP_ADDR_MIN 4'h5
`define SP_ADDR_MAX 4'hF
`define JUMP_HIGH_BITS 3
`define TRAP_VECTOR 11'h001
`define DEST_WORKING 1'h0
`define DEST_LOCATION 1'h1

// ============================================================================
// Reset values
// ============================================================================
`define PC_RESET 11'h000
`define DATA_RESET 8'h00

// ============================================================================
// Cycle counts of the multi-cycle operations
// ============================================================================
`define CYCLES_JUMP 2
`define CYCLES_SKIP 2
`define CYCLES_TRAP 3
`define EXTRA_JUMP 2'h1
`define EXTRA_SKIP 2'h1
`define EXTRA_TRAP 2'h2

`endif

/* register_file.v */
/*
 * Register file of 128 eight-bit locations with one write port and two
 * combinational read ports, one for execution and one for inspection.
 * Assumes the caller serialises writes into the single write port.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mcu_branch_defs.vh"

module register_file
(
   input wire core_clk,
   input wire writeEnable,
   input wire [`RF_ADDR_WIDTH-1:0] writeAddr,
   input wire [`DATA_WIDTH-1:0] writeData,
   input wire [`RF_ADDR_WIDTH-1:0] readAddr,
   output wire [`DATA_WIDTH-1:0] readData,
   input wire [`RF_ADDR_WIDTH-1:0] peekAddr,
   output wire [`DATA_WIDTH-1:0] peekData
);

   reg [`DATA_WIDTH-1:0] cells [0:`RF_DEPTH-1];

   // =========================================================================
   // Storage
   // =========================================================================
   always @(posedge core_clk)
   begin
      if (writeEnable)
      begin
         cells[writeAddr] <= writeData;
      end
   end

   assign readData = cells[readAddr];
   assign peekData = cells[peekAddr];

endmodule // register_file

`default_nettype wire

/* mcu_branch_exec.v */
/*
 * Execution unit for the computed jump, increment-skip-zero, software trap,
 * OR-immediate, OR-register and special page store operations, with the
 * program counter, working register, zero flag and register file.
 * Assumes requests, the jump high bits and the load port come from logic on
 * core_clk, and that the stack and special page registers accept a one-cycle
 * write strobe.
 */
// Overview of operation
// - Jump loads PC from high-bits and working register.
// - Increment location; select picks working register or location.
// - Zero result discards next instruction, two cycles.
// - Trap pushes next address, jumps to 001, three cycles.
// - OR immediate into working register, update zero.
// - OR location; select picks destination, update zero.
// - Store working register to special page, flags kept.
`timescale 1ns/100ps
`default_nettype none
`include "mcu_branch_defs.vh"

module mcu_branch_exec
(
   input wire core_clk,
   input wire rst,
   input wire opValid,
   input wire [`OP_WIDTH-1:0] opCode,
   input wire [`DATA_WIDTH-1:0] opOperand,
   input wire opDest,
   input wire [`DATA_WIDTH-1:0] jumpHighBits,
   input wire loadValid,
   input wire [`RF_ADDR_WIDTH-1:0] loadAddr,
   input wire [`DATA_WIDTH-1:0] loadData,
   input wire [`RF_ADDR_WIDTH-1:0] peekAddr,
   output reg [`DATA_WIDTH-1:0] peekDataReg,
   output reg busyReg,
   output reg [`PC_WIDTH-1:0] pcReg,
   output reg [`DATA_WIDTH-1:0] workingRegReg,
   output reg zeroFlagReg,
   output reg skipReg,
   output reg stackPushReg,
   output reg [`PC_WIDTH-1:0] stackDataReg,
   output reg spStrobeReg,
   output reg [`SP_ADDR_WIDTH-1:0] spAddrReg,
   output reg [`DATA_WIDTH-1:0] spDataReg
);

   localparam STATE_IDLE = 1'b0;
   localparam STATE_WAIT = 1'b1;

   // =========================================================================
   // Helpers
   // =========================================================================
   function isZero;
      input [`DATA_WIDTH-1:0] value;
      begin
         isZero = (value == `DATA_RESET);
      end
   endfunction

   function [`PC_WIDTH-1:0] pcPlus;
      input [`PC_WIDTH-1:0] pc;
      input [1:0] step;
      begin
         pcPlus = pc + {{(`PC_WIDTH-2){1'b0}}, step};
      end
   endfunction

   // =========================================================================
   // Register file
   // =========================================================================
   wire [`DATA_WIDTH-1:0] rfReadData;
   wire [`DATA_WIDTH-1:0] rfPeekData;
   reg rfWriteEnable;
   reg [`RF_ADDR_WIDTH-1:0] rfWriteAddr;
   reg [`DATA_WIDTH-1:0] rfWriteData;

   register_file registerFile
   (
      .core_clk(core_clk),
      .writeEnable(rfWriteEnable),
      .writeAddr(rfWriteAddr),
      .writeData(rfWriteData),
      .readAddr(opOperand[`RF_ADDR_WIDTH-1:0]),
      .readData(rfReadData),
      .peekAddr(peekAddr),
      .peekData(rfPeekData)
   );

   // =========================================================================
   // Next-state logic
   // =========================================================================
   reg state_reg;
   reg state_next;
   reg [1:0] extra_reg;
   reg [1:0] extra_next;
   reg [`PC_WIDTH-1:0] pc_next;
   reg [`DATA_WIDTH-1:0] working_next;
   reg zero_next;
   reg skip_next;
   reg push_next;
   reg [`PC_WIDTH-1:0] stack_next;
   reg sp_next;
   reg [`SP_ADDR_WIDTH-1:0] spAddr_next;
   reg [`DATA_WIDTH-1:0] spData_next;
   reg [`DATA_WIDTH-1:0] incSum;
   reg [`DATA_WIDTH-1:0] orResult;
   reg execWrite;
   wire take;

   // A request is taken only while no multi-cycle operation is running.
   assign take = opValid && (state_reg == STATE_IDLE);

   always @*
   begin
      state_next = state_reg;
      extra_next = extra_reg;
      pc_next = pcReg;
      working_next = workingRegReg;
      zero_next = zeroFlagReg;
      skip_next = 1'b0;
      push_next = 1'b0;
      stack_next = stackDataReg;
      sp_next = 1'b0;
      spAddr_next = spAddrReg;
      spData_next = spDataReg;
      execWrite = 1'b0;
      incSum = rfReadData + 8'h01;
      orResult = workingRegReg | rfReadData;
      case (state_reg)
         STATE_IDLE:
         begin
            if (take)
            begin
               pc_next = pcPlus(pcReg, 2'h1);
               case (opCode)
                  `OP_COMPUTED_JUMP:
                  begin
                     pc_next = {jumpHighBits[`JUMP_HIGH_BITS-1:0], workingRegReg};
                     extra_next = `EXTRA_JUMP;
                     state_next = STATE_WAIT;
                  end
                  `OP_INCREMENT_SKIP_ZERO:
                  begin
                     if (opDest == `DEST_WORKING)
                     begin
                        working_next = incSum;
                     end
                     else
                     begin
                        execWrite = 1'b1;
                     end
                     if (isZero(incSum))
                     begin
                        // The fetched successor is dropped and a no-op cycle follows.
                        pc_next = pcPlus(pcReg, 2'h2);
                        skip_next = 1'b1;
                        extra_next = `EXTRA_SKIP;
                        state_next = STATE_WAIT;
                     end
                  end
                  `OP_SOFTWARE_TRAP:
                  begin
                     push_next = 1'b1;
                     stack_next = pcPlus(pcReg, 2'h1);
                     pc_next = `TRAP_VECTOR;
                     extra_next = `EXTRA_TRAP;
                     state_next = STATE_WAIT;
                  end
                  `OP_OR_IMMEDIATE:
                  begin
                     working_next = workingRegReg | opOperand;
                     zero_next = isZero(workingRegReg | opOperand);
                  end
                  `OP_OR_REGISTER:
                  begin
                     if (opDest == `DEST_WORKING)
                     begin
                        working_next = orResult;
                     end
                     else
                     begin
                        execWrite = 1'b1;
                     end
                     zero_next = isZero(orResult);
                  end
                  `OP_SPECIAL_PAGE_STORE:
                  begin
                     // Operands outside the special page range are ignored.
                     if ((opOperand[`SP_ADDR_WIDTH-1:0] >= `SP_ADDR_MIN) &&
                         (opOperand[7:`SP_ADDR_WIDTH] == 4'h0))
                     begin
                        sp_next = 1'b1;
                        spAddr_next = opOperand[`SP_ADDR_WIDTH-1:0];
                        spData_next = workingRegReg;
                     end
                  end
                  default:
                  begin
                     pc_next = pcPlus(pcReg, 2'h1);
                  end
               endcase
            end
         end
         STATE_WAIT:
         begin
            extra_next = extra_reg - 2'h1;
            if (extra_reg == 2'h1)
            begin
               state_next = STATE_IDLE;
            end
         end
         default:
         begin
            state_next = STATE_IDLE;
            extra_next = 2'h0;
         end
      endcase
   end

   // Execution writes win over the load port in the same cycle.
   always @*
   begin
      rfWriteEnable = execWrite || loadValid;
      rfWriteAddr = loadAddr;
      rfWriteData = loadData;
      if (execWrite)
      begin
         rfWriteAddr = opOperand[`RF_ADDR_WIDTH-1:0];
         rfWriteData = (opCode == `OP_OR_REGISTER) ? orResult : incSum;
      end
   end

   // =========================================================================
   // State registers
   // =========================================================================
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= STATE_IDLE;
         extra_reg <= 2'h0;
         busyReg <= 1'b0;
         pcReg <= `PC_RESET;
         workingRegReg <= `DATA_RESET;
         zeroFlagReg <= 1'b0;
         skipReg <= 1'b0;
         stackPushReg <= 1'b0;
         stackDataReg <= `PC_RESET;
         spStrobeReg <= 1'b0;
         spAddrReg <= 4'h0;
         spDataReg <= `DATA_RESET;
         peekDataReg <= `DATA_RESET;
      end
      else
      begin
         state_reg <= state_next;
         extra_reg <= extra_next;
         busyReg <= (state_next == STATE_WAIT);
         pcReg <= pc_next;
         workingRegReg <= working_next;
         zeroFlagReg <= zero_next;
         skipReg <= skip_next;
         stackPushReg <= push_next;
         stackDataReg <= stack_next;
         spStrobeReg <= sp_next;
         spAddrReg <= spAddr_next;
         spDataReg <= spData_next;
         peekDataReg <= rfPeekData;
      end
   end

endmodule // mcu_branch_exec

`default_nettype wire

/* mcu_branch_props.sv */
/* Checker of the execution slice outputs against the operations taken.
   Assumes one clock domain and the defines of mcu_branch_defs.vh. */
`timescale 1ns/100ps
`default_nettype none
`include "mcu_branch_defs.vh"
module mcu_branch_props
(
   input wire core_clk,
   input wire rst,
   input wire opValid,
   input wire [2:0] opCode,
   input wire [7:0] opOperand,
   input wire opDest,
   input wire [7:0] jumpHighBits,
   input wire busyReg,
   input wire [10:0] pcReg,
   input wire [7:0] workingRegReg,
   input wire zeroFlagReg,
   input wire skipReg,
   input wire stackPushReg,
   input wire [10:0] stackDataReg,
   input wire spStrobeReg,
   input wire [3:0] spAddrReg,
   input wire [7:0] spDataReg
);
   // ==========
   // Helpers
   // Values seen before the last edge, so results can be tied to their causes.
   reg [10:0] prevPc;
   reg [7:0] prevAcc;
   reg [7:0] prevOpnd;
   reg [2:0] prevHb;
   reg prevZero;
   wire take;
   wire spOk;
   wire spTake;
   assign take = opValid && !busyReg;
   assign spOk = opOperand >= 8'h05 && opOperand <= 8'h0F;
   assign spTake = take && opCode == `OP_SPECIAL_PAGE_STORE && spOk;
   always @(posedge core_clk)
   begin
      prevPc <= pcReg;
      prevAcc <= workingRegReg;
      prevOpnd <= opOperand;
      prevHb <= jumpHighBits[2:0];
      prevZero <= zeroFlagReg;
   end
   // ==========
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_one_dead;
      busyReg ##1 !busyReg;
   endsequence
   sequence s_trap_tail;
      (!stackPushReg && busyReg) ##1 !busyReg;
   endsequence
   a_jump_target: assert property (take && opCode == `OP_COMPUTED_JUMP |=>
      pcReg == {prevHb, prevAcc} ##0 s_one_dead) else $error("jump target wrong");
   a_incr_skip: assert property (take && opCode == `OP_INCREMENT_SKIP_ZERO
      && opDest == `DEST_WORKING |=> skipReg == (workingRegReg == 8'h00))
      else $error("skip not tied to result");
   a_skip_pc: assert property (skipReg |-> pcReg == prevPc + 11'h2
      ##0 s_one_dead) else $error("skip timing wrong");
   a_trap_push: assert property (take && opCode == `OP_SOFTWARE_TRAP |=>
      stackPushReg && stackDataReg == prevPc + 11'h1 && pcReg == `TRAP_VECTOR
      && busyReg ##1 s_trap_tail) else $error("trap wrong");
   a_orimm_value: assert property (take && opCode == `OP_OR_IMMEDIATE |=>
      workingRegReg == (prevAcc | prevOpnd) && zeroFlagReg == (workingRegReg == 8'h00))
      else $error("or immediate wrong");
   a_orreg_flag: assert property (take && opCode == `OP_OR_REGISTER
      && opDest == `DEST_WORKING |=> zeroFlagReg == (workingRegReg == 8'h00)
      && pcReg == prevPc + 11'h1 && !busyReg) else $error("or register flag wrong");
   a_orreg_keep: assert property (take && opCode == `OP_OR_REGISTER
      && opDest == `DEST_LOCATION |=> workingRegReg == prevAcc)
      else $error("or register changed working register");
   // A back-to-back store legally keeps the strobe high for a second cycle.
   a_sp_store: assert property (spTake |=>
      spStrobeReg && spAddrReg == prevOpnd[3:0] && spDataReg == prevAcc
      && zeroFlagReg == prevZero ##1 (!spStrobeReg || $past(spTake)))
      else $error("store wrong");
   a_sp_refuse: assert property (take && opCode == `OP_SPECIAL_PAGE_STORE && !spOk
      |=> !spStrobeReg) else $error("bad store address accepted");
endmodule // mcu_branch_props
bind mcu_branch_exec mcu_branch_props u_mcu_branch_props
(
   .core_clk(core_clk),
   .rst(rst),
   .opValid(opValid),
   .opCode(opCode),
   .opOperand(opOperand),
   .opDest(opDest),
   .jumpHighBits(jumpHighBits),
   .busyReg(busyReg),
   .pcReg(pcReg),
   .workingRegReg(workingRegReg),
   .zeroFlagReg(zeroFlagReg),
   .skipReg(skipReg),
   .stackPushReg(stackPushReg),
   .stackDataReg(stackDataReg),
   .spStrobeReg(spStrobeReg),
   .spAddrReg(spAddrReg),
   .spDataReg(spDataReg)
);
`default_nettype wire

/* stack_sp_model.sv */
/* Model of the return stack top and the special page registers.
   Assumes one-cycle write strobes from the execution slice on core_clk. */
`timescale 1ns/100ps
`default_nettype none
module stack_sp_model
(
   input wire core_clk,
   input wire stackPushReg,
   input wire [10:0] stackDataReg,
   input wire spStrobeReg,
   input wire [3:0] spAddrReg,
   input wire [7:0] spDataReg
);
   // ==========
   // Storage
   reg [10:0] topOfStack;
   reg [7:0] spRegs [0:15];
   always @(posedge core_clk)
   begin
      if (stackPushReg)
         topOfStack <= stackDataReg;
      if (spStrobeReg)
         spRegs[spAddrReg] <= spDataReg;
   end
endmodule // stack_sp_model
`default_nettype wire

/* tb_top.sv */
/* Self-checking bench of the execution slice with the stack model.
   Assumes inputs change at the falling edge of core_clk. */
`timescale 1ns/100ps
`default_nettype none
`include "mcu_branch_defs.vh"
module tb_top;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg opValid = 1'b0;
   reg [2:0] opCode = 3'h0;
   reg [7:0] opOperand = 8'h00;
   reg opDest = 1'b0;
   reg [7:0] jumpHighBits = 8'h00;
   reg loadValid = 1'b0;
   reg [6:0] loadAddr = 7'h00;
   reg [7:0] loadData = 8'h00;
   reg [6:0] peekAddr = 7'h00;
   wire [7:0] peekDataReg, workingRegReg, spDataReg;
   wire [10:0] pcReg, stackDataReg;
   wire busyReg, zeroFlagReg, skipReg, stackPushReg, spStrobeReg;
   wire [3:0] spAddrReg;
   integer mismatches = 0;
   integer samples_checked = 0;
   integer cycles = 0;
   mcu_branch_exec u_mcu_branch_exec
   (
      .core_clk(core_clk),
      .rst(rst),
      .opValid(opValid),
      .opCode(opCode),
      .opOperand(opOperand),
      .opDest(opDest),
      .jumpHighBits(jumpHighBits),
      .loadValid(loadValid),
      .loadAddr(loadAddr),
      .loadData(loadData),
      .peekAddr(peekAddr),
      .peekDataReg(peekDataReg),
      .busyReg(busyReg),
      .pcReg(pcReg),
      .workingRegReg(workingRegReg),
      .zeroFlagReg(zeroFlagReg),
      .skipReg(skipReg),
      .stackPushReg(stackPushReg),
      .stackDataReg(stackDataReg),
      .spStrobeReg(spStrobeReg),
      .spAddrReg(spAddrReg),
      .spDataReg(spDataReg)
   );
   stack_sp_model u_stack_sp_model
   (
      .core_clk(core_clk),
      .stackPushReg(stackPushReg),
      .stackDataReg(stackDataReg),
      .spStrobeReg(spStrobeReg),
      .spAddrReg(spAddrReg),
      .spDataReg(spDataReg)
   );
   // ==========
   // Clock, timeout and shared tasks
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 2000)
      begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end
   task complete_run;
   begin
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // Holds a request until it is taken and leaves it up for a back-to-back request.
   task issue(input [2:0] c, input [7:0] a, input d);
   begin
      loadValid = 1'h0;
      opCode = c;
      opOperand = a;
      opDest = d;
      opValid = 1'h1;
      while (busyReg == 1'h1)
         @(negedge core_clk);
      @(negedge core_clk);
   end
   endtask
   task load(input [6:0] a, input [7:0] d);
   begin
      opValid = 1'h0;
      loadAddr = a;
      loadData = d;
      loadValid = 1'h1;
      @(negedge core_clk);
   end
   endtask
   // Drops every request and lets the given number of cycles pass.
   task pause(input integer n);
   begin
      opValid = 1'h0;
      loadValid = 1'h0;
      repeat (n) @(negedge core_clk);
   end
   endtask
   task peek(input [6:0] a);
   begin
      peekAddr = a;
      pause(2);
   end
   endtask
   // ==========
   // Scenarios
   task test_or_imm;
   begin
      issue(`OP_OR_IMMEDIATE, 8'h00, 1'b0);
      chk(zeroFlagReg, 1'b1);
      issue(`OP_OR_IMMEDIATE, 8'h34, 1'b0);
      issue(`OP_OR_IMMEDIATE, 8'h30, 1'b0);
      chk(workingRegReg, 8'h34);
      chk(zeroFlagReg, 1'b0);
      chk(pcReg, 11'h003);
   end
   endtask
   task test_jump;
   begin
      jumpHighBits = 8'hFA;
      issue(`OP_COMPUTED_JUMP, 8'h00, 1'b0);
      chk(pcReg, 11'h234);
      chk(busyReg, 1'b1);
      pause(1);
      chk(busyReg, 1'b0);
   end
   endtask
   task test_incr;
   begin
      load(7'h05, 8'hFF);
      load(7'h06, 8'h40);
      issue(`OP_INCREMENT_SKIP_ZERO, 8'h05, 1'b1);
      chk(skipReg, 1'b1);
      chk(busyReg, 1'b1);
      chk(pcReg, 11'h236);
      peek(7'h05);
      chk(peekDataReg, 8'h00);
      issue(`OP_INCREMENT_SKIP_ZERO, 8'h06, 1'b0);
      chk(workingRegReg, 8'h41);
      chk(skipReg, 1'b0);
      chk(pcReg, 11'h237);
   end
   endtask
   task test_or_reg;
   begin
      load(7'h07, 8'h82);
      issue(`OP_OR_REGISTER, 8'h07, 1'b1);
      chk(pcReg, 11'h238);
      chk(workingRegReg, 8'h41);
      issue(`OP_OR_REGISTER, 8'h07, 1'b0);
      chk(workingRegReg, 8'hC3);
      chk(zeroFlagReg, 1'b0);
      chk(pcReg, 11'h239);
      peek(7'h07);
      chk(peekDataReg, 8'hC3);
   end
   endtask
   task test_trap;
   begin
      issue(`OP_SOFTWARE_TRAP, 8'h00, 1'b0);
      chk(stackPushReg, 1'b1);
      chk(stackDataReg, 11'h23A);
      chk(pcReg, 11'h001);
      pause(1);
      chk(busyReg, 1'b1);
      chk(u_stack_sp_model.topOfStack, 11'h23A);
      pause(1);
      chk(busyReg, 1'b0);
   end
   endtask
   task test_sp;
   begin
      issue(`OP_SPECIAL_PAGE_STORE, 8'h05, 1'b0);
      chk(spStrobeReg, 1'b1);
      chk(spAddrReg, 4'h5);
      chk(spDataReg, 8'hC3);
      issue(`OP_SPECIAL_PAGE_STORE, 8'h0F, 1'b0);
      chk(spAddrReg, 4'hF);
      issue(`OP_SPECIAL_PAGE_STORE, 8'h04, 1'b0);
      chk(spStrobeReg, 1'b0);
      chk(pcReg, 11'h004);
      chk(u_stack_sp_model.spRegs[15], 8'hC3);
   end
   endtask
   initial
   begin
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      test_or_imm;
      test_jump;
      test_incr;
      test_or_reg;
      test_trap;
      test_sp;
      complete_run;
   end
endmodule // tb_top
`default_nettype wire
